// [src/swg_defs.vh]
`ifndef SWG_DEFS_VH
`define SWG_DEFS_VH

// Word byte addresses on the Wishbone slave (index * 4)
`define SWG_ADDR_W            6
`define SWG_OFF_PROT_CMD      6'h00
`define SWG_OFF_SYS_STATUS    6'h04
`define SWG_OFF_PWR_SAVE      6'h08
`define SWG_OFF_CLK_CTRL      6'h0C
`define SWG_OFF_PROC_CLK      6'h10
`define SWG_OFF_CLK_MON       6'h14
`define SWG_OFF_RST_SRC       6'h18
`define SWG_OFF_RAM_STAT      6'h1C
`define SWG_OFF_DBG_MODE      6'h20
`define SWG_OFF_IRQ_STATUS    6'h24
`define SWG_OFF_IRQ_MASK      6'h28
`define SWG_OFF_BIT_OP        6'h2C

// Number of guarded registers
`define SWG_NUM_GUARD         7

// Field positions
`define SWG_SYS_PROTECTION_ERROR_FLAG_BIT     0
`define SWG_IRQ_PROT_ERR_BIT  0
`define SWG_IRQ_GUARD_WR_BIT  1
`define SWG_IRQ_W             2
`define SWG_BITOP_IDX_LSB     0
`define SWG_BITOP_IDX_MSB     3
`define SWG_BITOP_BIT_LSB     8
`define SWG_BITOP_BIT_MSB     10
`define SWG_BITOP_OP_LSB      16
`define SWG_BITOP_OP_MSB      17

// Bit operation codes
`define SWG_OP_SET            2'h1
`define SWG_OP_CLR            2'h2
`define SWG_OP_INV            2'h3

// Reset values
`define SWG_RST_BYTE          8'h00
`define SWG_RST_SYS           8'h00
`define SWG_UNDEF_READ        8'h00

`endif

// [src/swg_seq.v]
`timescale 1ns/1ps
`include "swg_defs.vh"

// Unlock sequencer: tracks the one-shot window after a command write
module swg_seq (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       wr_cmd_i,
	input  wire       wr_guard_i,
	input  wire       wr_other_i,
	output wire       unlocked_o,
	output wire       grant_o,
	output wire       violation_o
);
	localparam ST_LOCKED = 1'b0;
	localparam ST_OPEN   = 1'b1;

	reg state_reg;
	reg state_next;

	assign unlocked_o  = (state_reg == ST_OPEN);
	assign grant_o     = unlocked_o & wr_guard_i; // [R2]
	// Guard write while locked, other write or repeat command while open
	assign violation_o = (~unlocked_o & wr_guard_i) // [R4]
	                   | (unlocked_o & wr_other_i)  // [R5]
	                   | (unlocked_o & wr_cmd_i);   // [R7]

	always @* begin
		case (state_reg)
			ST_LOCKED: begin
				state_next = wr_cmd_i ? ST_OPEN : ST_LOCKED;
			end
			ST_OPEN: begin
				// Any write closes the window; reads leave it open
				if (wr_cmd_i | wr_guard_i | wr_other_i) begin // [R17] [R6]
					state_next = ST_LOCKED;
				end else begin
					state_next = ST_OPEN;
				end
			end
			default: begin
				state_next = ST_LOCKED;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_LOCKED;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule // swg_seq

// [src/swg_top.v]
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "swg_defs.vh"

// Overview of operation
// [R1] Command register is 8-bit write-only
// [R2] First guarded write after command succeeds
// [R3] Guarded registers change only via unlock
// [R4] Locked guarded write sets error flag
// [R5] Unguarded write after command sets flag
// [R6] Plain reads keep pending unlock intact
// [R7] Repeated command write sets error flag
// [R8] Writing zero clears flag, wins race
// [R9] Status register resets to zero
// [R10] Byte and single-bit status access
// [R11] Interrupts held off after command write
// [R12] Guarded registers readable anytime, no effect
// [R13] Exactly seven guarded registers
// [R14] CPU: command write then guarded store
// [R15] CPU: five idle instructions after standby
// [R16] CPU: same source register for both
// [R17] Any write ends the pending unlock; here a write without byte lane 0 (sel_i[0] low) is acked but leaves it open
module swg_top (
	input  wire                      clk_i,
	input  wire                      rst_i,
	input  wire                      cyc_i,
	input  wire                      stb_i,
	input  wire                      we_i,
	input  wire [`SWG_ADDR_W-1:0]    adr_i,
	input  wire [3:0]                sel_i,
	input  wire [31:0]               dat_i,
	output reg  [31:0]               dat_o,
	output reg                       ack_o,
	output reg                       err_o,
	output reg                       irq_o,
	output reg                       irq_hold_o,
	output reg  [7:0]                power_save_control_o,
	output reg  [7:0]                clock_control_reg_o,
	output reg  [7:0]                processor_clock_control_o,
	output reg  [7:0]                clock_monitor_mode_o,
	output reg  [7:0]                reset_source_flags_o,
	output reg  [7:0]                ram_data_status_o,
	output reg  [7:0]                debug_mode_reg_o,
	output reg                       protection_error_flag_o
);
	// Guarded register storage, index 0..6
	reg  [7:0] guard_reg [0:`SWG_NUM_GUARD-1]; // [R13]
	reg  [7:0] sys_reg;
	reg  [`SWG_IRQ_W-1:0] irq_stat_reg;
	reg  [`SWG_IRQ_W-1:0] irq_mask_reg;

	// Single access per request: ack closes the cycle
	wire       req      = cyc_i & stb_i & ~ack_o & ~err_o;
	wire       byte0    = sel_i[0];
	wire       is_cmd   = (adr_i == `SWG_OFF_PROT_CMD);
	wire       is_sys   = (adr_i == `SWG_OFF_SYS_STATUS);
	wire       is_bitop = (adr_i == `SWG_OFF_BIT_OP);
	wire       is_istat = (adr_i == `SWG_OFF_IRQ_STATUS);
	wire       is_imask = (adr_i == `SWG_OFF_IRQ_MASK);

	// Map an address to a guarded index, 7 when not guarded
	function [2:0] guard_index;
		input [`SWG_ADDR_W-1:0] a;
		begin
			case (a)
				`SWG_OFF_PWR_SAVE: guard_index = 3'd0;
				`SWG_OFF_CLK_CTRL: guard_index = 3'd1;
				`SWG_OFF_PROC_CLK: guard_index = 3'd2;
				`SWG_OFF_CLK_MON:  guard_index = 3'd3;
				`SWG_OFF_RST_SRC:  guard_index = 3'd4;
				`SWG_OFF_RAM_STAT: guard_index = 3'd5;
				`SWG_OFF_DBG_MODE: guard_index = 3'd6;
				default:           guard_index = 3'd7;
			endcase
		end
	endfunction

	// Bit operation: read-modify-write of one bit of a target
	function [7:0] bit_apply;
		input [7:0] v;
		input [2:0] b;
		input [1:0] op;
		reg   [7:0] m;
		begin
			m = 8'h01 << b;
			case (op)
				`SWG_OP_SET: bit_apply = v | m;
				`SWG_OP_CLR: bit_apply = v & ~m;
				`SWG_OP_INV: bit_apply = v ^ m;
				default:     bit_apply = v;
			endcase
		end
	endfunction

	wire [2:0] adr_gidx = guard_index(adr_i);
	wire [3:0] bo_tgt   = dat_i[`SWG_BITOP_IDX_MSB:`SWG_BITOP_IDX_LSB];
	wire [2:0] bo_bit   = dat_i[`SWG_BITOP_BIT_MSB:`SWG_BITOP_BIT_LSB];
	wire [1:0] bo_op    = dat_i[`SWG_BITOP_OP_MSB:`SWG_BITOP_OP_LSB];
	// Bit op target: 0..6 guarded, 7 status register, others invalid
	wire       bo_guard = (bo_tgt < 4'd7);
	wire       bo_sys   = (bo_tgt == 4'd7);
	wire       bo_valid = bo_guard | bo_sys;

	wire       known    = is_cmd | is_sys | is_bitop | is_istat | is_imask | (adr_gidx != 3'd7);
	wire       wr       = req & we_i & known & byte0;
	wire       rd       = req & ~we_i & known;

	wire       wr_cmd   = wr & is_cmd;
	wire       wr_guard = wr & (((adr_gidx != 3'd7)) | (is_bitop & bo_guard));
	// Bit ops count as writes even on unguarded targets
	wire       wr_other = wr & ~wr_cmd & ~wr_guard;
	wire [2:0] tgt_idx  = is_bitop ? bo_tgt[2:0] : adr_gidx;

	wire       unlocked;
	wire       grant;
	wire       violation;

	swg_seq u_seq (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.wr_cmd_i    (wr_cmd),
		.wr_guard_i  (wr_guard),
		.wr_other_i  (wr_other),
		.unlocked_o  (unlocked),
		.grant_o     (grant),
		.violation_o (violation)
	);

	// Status register next value
	reg  [7:0] sys_next;
	reg        sys_cleared;
	always @* begin
		sys_next    = sys_reg;
		sys_cleared = 1'b0;
		if (wr & is_sys) begin
			sys_next    = dat_i[7:0]; // [R10]
			sys_cleared = ~dat_i[`SWG_SYS_PROTECTION_ERROR_FLAG_BIT];
		end else if (wr & is_bitop & bo_sys) begin
			sys_next    = bit_apply(sys_reg, bo_bit, bo_op); // [R10]
			sys_cleared = ~sys_next[`SWG_SYS_PROTECTION_ERROR_FLAG_BIT];
		end
		// A zero written to the flag beats the violation of that same write
		if (violation & ~sys_cleared) begin // [R8]
			sys_next[`SWG_SYS_PROTECTION_ERROR_FLAG_BIT] = 1'b1; // [R4] [R5] [R7]
		end
		// Other status bits have no hardware meaning yet; keep them writable
	end

	wire [`SWG_IRQ_W-1:0] irq_events = {grant, violation & ~sys_cleared};
	wire [`SWG_IRQ_W-1:0] irq_stat_next =
		(irq_stat_reg & ~((wr & is_istat) ? dat_i[`SWG_IRQ_W-1:0] : {`SWG_IRQ_W{1'b0}})) | irq_events;

	// Read mux
	reg [7:0] rd_data;
	always @* begin
		rd_data = 8'h00;
		if (is_cmd) begin
			rd_data = `SWG_UNDEF_READ; // [R1]
		end else if (is_sys) begin
			rd_data = sys_reg;
		end else if (is_istat) begin
			rd_data = {{(8-`SWG_IRQ_W){1'b0}}, irq_stat_reg};
		end else if (is_imask) begin
			rd_data = {{(8-`SWG_IRQ_W){1'b0}}, irq_mask_reg};
		end else if (adr_gidx != 3'd7) begin
			rd_data = guard_reg[adr_gidx]; // [R12]
		end
	end

	integer i;
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < `SWG_NUM_GUARD; i = i + 1) begin
				guard_reg[i] <= `SWG_RST_BYTE;
			end
			sys_reg      <= `SWG_RST_SYS; // [R9]
			irq_stat_reg <= {`SWG_IRQ_W{1'b0}};
			irq_mask_reg <= {`SWG_IRQ_W{1'b0}};
			ack_o        <= 1'b0;
			err_o        <= 1'b0;
			dat_o        <= 32'h0000_0000;
			irq_o        <= 1'b0;
			irq_hold_o   <= 1'b0;
			power_save_control_o      <= `SWG_RST_BYTE;
			clock_control_reg_o       <= `SWG_RST_BYTE;
			processor_clock_control_o <= `SWG_RST_BYTE;
			clock_monitor_mode_o      <= `SWG_RST_BYTE;
			reset_source_flags_o      <= `SWG_RST_BYTE;
			ram_data_status_o         <= `SWG_RST_BYTE;
			debug_mode_reg_o          <= `SWG_RST_BYTE;
			protection_error_flag_o   <= 1'b0;
		end else begin
			ack_o <= req & known;
			err_o <= req & ~known;
			dat_o <= rd ? {24'h00_0000, rd_data} : 32'h0000_0000;
			// Only a granted write reaches a guarded register
			if (grant) begin // [R3]
				guard_reg[tgt_idx] <= is_bitop ? bit_apply(guard_reg[tgt_idx], bo_bit, bo_op)
				                               : dat_i[7:0]; // [R2]
			end
			sys_reg      <= sys_next;
			irq_stat_reg <= irq_stat_next;
			if (wr & is_imask) begin
				irq_mask_reg <= dat_i[`SWG_IRQ_W-1:0];
			end
			irq_o      <= |(irq_stat_next & irq_mask_reg);
			// Held while the window is open so the guarded store is not split
			irq_hold_o <= wr_cmd | (unlocked & ~(wr_guard | wr_other)); // [R11]
			power_save_control_o      <= guard_reg[0];
			clock_control_reg_o       <= guard_reg[1];
			processor_clock_control_o <= guard_reg[2];
			clock_monitor_mode_o      <= guard_reg[3];
			reset_source_flags_o      <= guard_reg[4];
			ram_data_status_o         <= guard_reg[5];
			debug_mode_reg_o          <= guard_reg[6];
			protection_error_flag_o   <= sys_next[`SWG_SYS_PROTECTION_ERROR_FLAG_BIT];
		end
	end
endmodule // swg_top

// [tb/swg_chk.sv]
`timescale 1ns/1ps
`include "swg_defs.vh"
module swg_chk (
	input wire                   clk_i,
	input wire                   rst_i,
	input wire                   cyc_i,
	input wire                   stb_i,
	input wire                   we_i,
	input wire [`SWG_ADDR_W-1:0] adr_i,
	input wire [31:0]            dat_o,
	input wire                   ack_o,
	input wire                   err_o,
	input wire                   irq_hold_o,
	input wire [7:0]             power_save_control_o,
	input wire [7:0]             debug_mode_reg_o,
	input wire                   protection_error_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		cyc_i && stb_i && !ack_o && !err_o;
	endsequence
	sequence s_rd_done;
		ack_o && !we_i;
	endsequence
	chk_ack_one_shot: assert property (s_take ##0 (adr_i <= 6'h2C && adr_i[1:0] == 2'b00) |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse");
	chk_err_unmapped: assert property (s_take ##0 (adr_i > 6'h2C || adr_i[1:0] != 2'b00) |=> err_o && !ack_o)
		else $error("unmapped access not refused");
	// Guarded copies lag the taking edge by one cycle
	chk_guard_gate: assert property (!$stable({power_save_control_o, debug_mode_reg_o})
		|-> $past(ack_o) && $past(irq_hold_o, 2)) else $error("guarded change without unlock");
	chk_flag_on_ack: assert property (!$stable(protection_error_flag_o) |-> ack_o)
		else $error("flag moved outside an access");
	chk_read_no_effect: assert property (s_rd_done |-> $stable(irq_hold_o) && $stable(protection_error_flag_o))
		else $error("read disturbed protection state");
	chk_cmd_reads_zero: assert property (s_rd_done ##0 (adr_i == `SWG_OFF_PROT_CMD)
		|-> dat_o == {24'h00_0000, `SWG_UNDEF_READ}) else $error("command read not blank");
	chk_write_closes: assert property (ack_o && we_i && adr_i != `SWG_OFF_PROT_CMD |-> !irq_hold_o)
		else $error("unlock survived a write");
	chk_cmd_holds: assert property (ack_o && we_i && adr_i == `SWG_OFF_PROT_CMD |-> irq_hold_o)
		else $error("interrupts not held off");
	chk_reset_clear: assert property ($fell(rst_i) |-> !protection_error_flag_o && power_save_control_o == 8'h00)
		else $error("reset left state");
endmodule // swg_chk
bind swg_top swg_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .err_o, .irq_hold_o,
	.power_save_control_o, .debug_mode_reg_o, .protection_error_flag_o);

// [tb/swg_cpu.sv]
`timescale 1ns/1ps
`include "swg_defs.vh"
module swg_cpu (
	input  wire        clk_i,
	input  wire        ack_i,
	input  wire        err_i,
	input  wire [31:0] rdat_i,
	output reg         cyc_o = 1'b0,
	output reg         stb_o = 1'b0,
	output reg         we_o = 1'b0,
	output reg  [5:0]  adr_o = 6'h00,
	output reg  [3:0]  sel_o = 4'h0,
	output reg  [31:0] dat_o = 32'h0000_0000
);
	// Byte lanes of the next request; a bench may clear lane 0 to test a write that is acked but ignored
	logic [3:0] lane = 4'h1;
	task wb(input w, input [5:0] a, input [31:0] d, output [32:0] r);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= lane;
		dat_o <= d;
		// No own limit: only the bench watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (!(ack_i || err_i));
		r = {err_i, rdat_i};
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		// Released lines show garbage, not the last value
		we_o <= ~w;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask
	task unlock(input [5:0] a, input [31:0] d);
		logic [32:0] r;
		wb(1'b1, `SWG_OFF_PROT_CMD, d, r);
		wb(1'b1, a, d, r);
		if (a == `SWG_OFF_PWR_SAVE) repeat (5) @(posedge clk_i);
	endtask
endmodule // swg_cpu

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "swg_defs.vh"
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wire         cyc, stb, we, ack, err, irq, hold, flag;
	wire  [5:0]  adr;
	wire  [3:0]  sel;
	wire  [31:0] wdat, rdat;
	wire  [7:0]  gv [0:6];
	logic [32:0] r;
	int          mismatches = 0;
	int          tests_run = 0;
	swg_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err), .irq_o(irq), .irq_hold_o(hold),
		.power_save_control_o(gv[0]), .clock_control_reg_o(gv[1]), .processor_clock_control_o(gv[2]),
		.clock_monitor_mode_o(gv[3]), .reset_source_flags_o(gv[4]), .ram_data_status_o(gv[5]),
		.debug_mode_reg_o(gv[6]), .protection_error_flag_o(flag));
	swg_cpu cpu (.clk_i(clk_i), .ack_i(ack), .err_i(err), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));
	initial forever #12.5 clk_i = ~clk_i;
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task settle;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task t_reset;
		for (int i = 0; i < 7; i++) chk(gv[i], 8'h00);
		chk(flag, 1'b0);
		cpu.wb(1'b0, `SWG_OFF_SYS_STATUS, 32'h0000_0000, r);
		chk(r[31:0], 32'h0000_0000);
		cpu.wb(1'b0, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		chk(r[31:0], 32'h0000_0000);
		cpu.wb(1'b0, 6'h30, 32'h0000_0000, r);
		chk(r[32], 1'b1);
	endtask
	task t_unlock;
		for (int i = 0; i < 7; i++) begin
			cpu.unlock(`SWG_OFF_PWR_SAVE + 6'(i * 4), 32'(8'hA0 + i));
			settle;
			chk(gv[i], 32'(8'hA0 + i));
			cpu.wb(1'b0, `SWG_OFF_PWR_SAVE + 6'(i * 4), 32'h0000_0000, r);
			chk(r[31:0], 32'(8'hA0 + i));
			chk(flag, 1'b0);
		end
	endtask
	task t_locked;
		cpu.wb(1'b1, `SWG_OFF_PWR_SAVE, 32'h0000_00FF, r);
		settle;
		chk(gv[0], 8'hA0);
		chk(flag, 1'b1);
		cpu.wb(1'b1, `SWG_OFF_BIT_OP, 32'h0003_0001, r);
		settle;
		chk(gv[1], 8'hA1);
		cpu.wb(1'b1, `SWG_OFF_BIT_OP, 32'h0002_0007, r);
		settle;
		chk(flag, 1'b0);
	endtask
	task t_unguarded;
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		#1;
		chk(hold, 1'b1);
		cpu.wb(1'b1, `SWG_OFF_IRQ_MASK, 32'h0000_0001, r);
		settle;
		chk(flag, 1'b1);
		chk(hold, 1'b0);
		chk(irq, 1'b1);
		cpu.wb(1'b1, `SWG_OFF_IRQ_MASK, 32'h0000_0000, r);
		settle;
		chk(irq, 1'b0);
		cpu.wb(1'b1, `SWG_OFF_IRQ_MASK, 32'h0000_0001, r);
		settle;
		chk(irq, 1'b1);
		cpu.wb(1'b1, `SWG_OFF_IRQ_STATUS, 32'h0000_0003, r);
		settle;
		chk(irq, 1'b0);
		cpu.wb(1'b1, `SWG_OFF_SYS_STATUS, 32'h0000_0000, r);
		// Write without the low byte lane is acked but has no effect
		cpu.lane = 4'h0;
		cpu.wb(1'b1, `SWG_OFF_PWR_SAVE, 32'h0000_00FF, r);
		cpu.lane = 4'h1;
		settle;
		chk(gv[0], 8'hA0);
		chk(flag, 1'b0);
	endtask
	task t_between;
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0033, r);
		cpu.wb(1'b0, `SWG_OFF_SYS_STATUS, 32'h0000_0000, r);
		cpu.wb(1'b0, `SWG_OFF_CLK_CTRL, 32'h0000_0000, r);
		cpu.wb(1'b1, `SWG_OFF_PWR_SAVE, 32'h0000_0033, r);
		settle;
		chk(gv[0], 8'h33);
		chk(flag, 1'b0);
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		cpu.wb(1'b1, `SWG_OFF_BIT_OP, 32'h0001_0200, r);
		settle;
		chk(gv[0], 8'h37);
	endtask
	task t_double;
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		settle;
		chk(flag, 1'b1);
		cpu.wb(1'b1, `SWG_OFF_PROT_CMD, 32'h0000_0000, r);
		cpu.wb(1'b1, `SWG_OFF_SYS_STATUS, 32'h0000_0000, r);
		settle;
		chk(flag, 1'b0);
		chk(hold, 1'b0);
	endtask
	task results;
		if (mismatches == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_unlock;
		t_locked;
		t_unguarded;
		t_between;
		t_double;
		// Mid-run reset must drop state set above
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		settle;
		t_reset;
		results;
	end
	initial begin
		#50000;
		mismatches++;
		results;
	end
endmodule // tb_top
